// file: wake_and_supply_status_regs.v
/*
 * Wake source, input level, regulator fault and identification status
 * registers, read by address over the serial control port; the wake and regulator fault ones are also cleared.
 * Also counts watchdog trigger failures to drive the fail outputs.
 * Assumes the serial framing decodes reads and clears into one-cycle
 * strobes with a 7-bit address, and that all inputs are synchronous.
 */
//
// Functional notes
// - Latch regulator automatic modulation switch in bit 7.
// - Latch CAN, timer, wake pin wakes.
// - One latched wake flag per LIN bus.
// - Reserved bits read as zero.
// - Input level bit 6 reads one.
// - Bit 7 shows development pin; blocks watchdog reset.
// - Bit 5 mirrors fail-output configuration bit.
// - Fail outputs after second or first failure.
// - Boost diode or sense short sets bit 6.
// - Bit 5 ORs three boost open detections.
// - Gate short sets bit 4; active sets 7.
// - Buck switch short sets bit 2.
// - Buck switch open sets bit 1.
// - Bit 0 flags main output out of band.
// - Read-only family and product identification byte.
// - Reset clears wakes, regulator upper nibble; restart keeps.
`timescale 1ns/100ps
`include "wake_supply_regs.vh"
module wake_and_supply_status_regs #(
  // Identification codes below are arbitrary values.
  parameter [3:0] FAMILY_CODE = 4'hA,
  parameter [3:0] PRODUCT_CODE = 4'h3
) (
  // Clock, reset and enable.
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  input wire soft_reset,
  // Register access from the serial control port.
  input wire [6:0] reg_addr,
  input wire reg_rd,
  input wire reg_clr,
  output reg [7:0] reg_rdata,
  output reg reg_rvalid,
  // Wake events.
  input wire regulator_mode_auto_switch,
  input wire can_bus_wake,
  input wire cyclic_timer_wake,
  input wire wake_pin_wake,
  input wire [3:0] lin_wake,
  // Live pin and configuration levels.
  input wire wake_input_pin,
  input wire dev_mode_pin,
  input wire fail_output_config_bit,
  // Regulator monitors.
  input wire boost_running,
  input wire boost_diode_short,
  input wire positive_sense_short,
  input wire boost_diode_lost,
  input wire positive_sense_lost,
  input wire negative_sense_gnd_lost,
  input wire boost_gate_short,
  input wire buck_switch_short,
  input wire buck_switch_open,
  input wire main_output_out_of_band,
  // Watchdog trigger results.
  input wire wd_trigger_fail,
  input wire wd_trigger_ok,
  output reg fail_outputs,
  output reg wd_reset_req
);
  wire [7:0] wake_a_flags;
  wire [3:0] wake_b_flags;
  wire [7:0] reg_flags;
  wire [7:0] wake_a_set;
  wire [7:0] reg_set;
  wire [7:0] wake_a_clr;
  wire [3:0] wake_b_clr;
  wire [7:0] reg_clr_mask;
  wire [7:0] wake_a_init;
  wire [3:0] wake_b_init;
  wire [7:0] reg_init;
  wire [7:0] level_val;
  wire [1:0] fail_limit;
  reg [1:0] fail_cnt_r;
  reg [1:0] fail_cnt_nxt;
  reg [7:0] rdata_nxt;
  reg fail_outputs_nxt;
  reg wd_reset_req_nxt;
  wire hit_wake_a;
  wire hit_wake_b;
  wire hit_level;
  wire hit_regulator;
  wire hit_ident;
  wire clr_wake_a;
  wire clr_wake_b;
  wire clr_regulator;
  wire regulator_mode_auto_switch_flag;
  wire can_bus_wake_flag;
  wire cyclic_timer_wake_flag;
  wire wake_pin_wake_flag;
  wire lin_first_wake_flag;
  wire lin_second_wake_flag;
  wire lin_third_wake_flag;
  wire lin_fourth_wake_flag;
  wire boost_active_flag;
  wire boost_sense_short_flag;
  wire boost_open_flag;
  wire boost_gate_short_flag;
  wire buck_switch_short_flag;
  wire buck_switch_open_flag;
  wire core_supply_out_of_range_flag;
  wire fail_output_config_mirror;
  wire [3:0] family_code;
  wire [3:0] product_variant_code;
  wire [7:0] wake_a_view;
  wire [7:0] wake_b_view;
  wire [7:0] regulator_view;
  wire [7:0] ident_view;

  assign wake_a_set[`WKA_MODE_SWITCH] = regulator_mode_auto_switch;
  assign wake_a_set[`WKA_RESERVED] = 1'b0;
  assign wake_a_set[`WKA_CAN] = can_bus_wake;
  assign wake_a_set[`WKA_TIMER] = cyclic_timer_wake;
  assign wake_a_set[`WKA_RSVD_HI:`WKA_RSVD_LO] = 3'h0;
  assign wake_a_set[`WKA_PIN] = wake_pin_wake;

  assign reg_set[`REG_BOOST_ACTIVE] = boost_running;
  assign reg_set[`REG_BOOST_SHORT] = boost_diode_short | positive_sense_short;
  assign reg_set[`REG_BOOST_OPEN] = boost_diode_lost | positive_sense_lost |
    negative_sense_gnd_lost;
  assign reg_set[`REG_BOOST_GATE] = boost_gate_short;
  assign reg_set[`REG_RESERVED] = 1'b0;
  assign reg_set[`REG_BUCK_SHORT] = buck_switch_short;
  assign reg_set[`REG_BUCK_OPEN] = buck_switch_open;
  // Stays set while out of band, so a clear only takes once back inside.
  assign reg_set[`REG_OUT_RANGE] = main_output_out_of_band;

  // One address decode serves both reads and clear commands.
  assign hit_wake_a = (reg_addr == `ADDR_WAKE_A);
  assign hit_wake_b = (reg_addr == `ADDR_WAKE_B);
  assign hit_level = (reg_addr == `ADDR_LEVEL);
  assign hit_regulator = (reg_addr == `ADDR_REGULATOR);
  assign hit_ident = (reg_addr == `ADDR_IDENT);
  assign clr_wake_a = reg_clr & hit_wake_a;
  assign clr_wake_b = reg_clr & hit_wake_b;
  assign clr_regulator = reg_clr & hit_regulator;

  // Clear commands affect only the clearable bits of the addressed register.
  assign wake_a_clr = clr_wake_a ? `WKA_RC_MASK : 8'h00;
  assign wake_b_clr = clr_wake_b ? `WKB_RC_MASK : 4'h0;
  assign reg_clr_mask = clr_regulator ? `REG_RC_MASK : 8'h00;

  // Soft reset acts like power-on on these bits; restart touches nothing here.
  assign wake_a_init = soft_reset ? 8'hFF : 8'h00;
  assign wake_b_init = soft_reset ? 4'hF : 4'h0;
  assign reg_init = soft_reset ? `REG_UPPER_MASK : 8'h00;

  sticky_flags #(.W(8)) u_wake_a (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .set_in(wake_a_set),
    .clr_mask(wake_a_clr),
    .init_mask(wake_a_init),
    .flags(wake_a_flags)
  );

  sticky_flags #(.W(4)) u_wake_b (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .set_in(lin_wake),
    .clr_mask(wake_b_clr),
    .init_mask(wake_b_init),
    .flags(wake_b_flags)
  );

  sticky_flags #(.W(8)) u_regulator (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ce(ce),
    .set_in(reg_set),
    .clr_mask(reg_clr_mask),
    .init_mask(reg_init),
    .flags(reg_flags)
  );

  // Named fields of the latched flags.
  assign regulator_mode_auto_switch_flag = wake_a_flags[`WKA_MODE_SWITCH];
  assign can_bus_wake_flag = wake_a_flags[`WKA_CAN];
  assign cyclic_timer_wake_flag = wake_a_flags[`WKA_TIMER];
  assign wake_pin_wake_flag = wake_a_flags[`WKA_PIN];
  assign lin_first_wake_flag = wake_b_flags[`WKB_LIN1];
  assign lin_second_wake_flag = wake_b_flags[`WKB_LIN2];
  assign lin_third_wake_flag = wake_b_flags[`WKB_LIN3];
  assign lin_fourth_wake_flag = wake_b_flags[`WKB_LIN4];
  assign boost_active_flag = reg_flags[`REG_BOOST_ACTIVE];
  assign boost_sense_short_flag = reg_flags[`REG_BOOST_SHORT];
  assign boost_open_flag = reg_flags[`REG_BOOST_OPEN];
  assign boost_gate_short_flag = reg_flags[`REG_BOOST_GATE];
  assign buck_switch_short_flag = reg_flags[`REG_BUCK_SHORT];
  assign buck_switch_open_flag = reg_flags[`REG_BUCK_OPEN];
  assign core_supply_out_of_range_flag = reg_flags[`REG_OUT_RANGE];
  assign fail_output_config_mirror = fail_output_config_bit;
  assign family_code = FAMILY_CODE;
  assign product_variant_code = PRODUCT_CODE;

  // Read images; reserved positions are tied here, whatever the flag banks hold.
  assign wake_a_view[`WKA_MODE_SWITCH] = regulator_mode_auto_switch_flag;
  assign wake_a_view[`WKA_RESERVED] = 1'b0;
  assign wake_a_view[`WKA_CAN] = can_bus_wake_flag;
  assign wake_a_view[`WKA_TIMER] = cyclic_timer_wake_flag;
  assign wake_a_view[`WKA_RSVD_HI:`WKA_RSVD_LO] = 3'h0;
  assign wake_a_view[`WKA_PIN] = wake_pin_wake_flag;

  assign wake_b_view[`WKB_RSVD_HI:`WKB_RSVD_LO] = 4'h0;
  assign wake_b_view[`WKB_LIN4] = lin_fourth_wake_flag;
  assign wake_b_view[`WKB_LIN3] = lin_third_wake_flag;
  assign wake_b_view[`WKB_LIN2] = lin_second_wake_flag;
  assign wake_b_view[`WKB_LIN1] = lin_first_wake_flag;

  assign level_val[`LVL_DEV_PIN] = dev_mode_pin;
  assign level_val[`LVL_FIXED_ONE] = 1'b1;
  assign level_val[`LVL_FAIL_CFG] = fail_output_config_mirror;
  assign level_val[`LVL_RSVD_HI:`LVL_RSVD_LO] = 4'h0;
  assign level_val[`LVL_WAKE_PIN] = wake_input_pin;

  assign regulator_view[`REG_BOOST_ACTIVE] = boost_active_flag;
  assign regulator_view[`REG_BOOST_SHORT] = boost_sense_short_flag;
  assign regulator_view[`REG_BOOST_OPEN] = boost_open_flag;
  assign regulator_view[`REG_BOOST_GATE] = boost_gate_short_flag;
  assign regulator_view[`REG_RESERVED] = 1'b0;
  assign regulator_view[`REG_BUCK_SHORT] = buck_switch_short_flag;
  assign regulator_view[`REG_BUCK_OPEN] = buck_switch_open_flag;
  assign regulator_view[`REG_OUT_RANGE] = core_supply_out_of_range_flag;

  assign ident_view[`ID_FAM_HI:`ID_FAM_LO] = family_code;
  assign ident_view[`ID_PRODUCT_VARIANT_CODE_HI:`ID_PRODUCT_VARIANT_CODE_LO] = product_variant_code;

  always @* begin
    // Unmapped addresses read as zero.
    rdata_nxt = 8'h00;
    if (hit_wake_a) begin
      rdata_nxt = wake_a_view;
    end else if (hit_wake_b) begin
      rdata_nxt = wake_b_view;
    end else if (hit_level) begin
      rdata_nxt = level_val;
    end else if (hit_regulator) begin
      rdata_nxt = regulator_view;
    end else if (hit_ident) begin
      rdata_nxt = ident_view;
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      reg_rdata <= `RESET_ZERO;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // Mirror zero waits for the second failure, one acts on the first.
  assign fail_limit = fail_output_config_mirror ? `FAIL_COUNT_CFG_SET :
    `FAIL_COUNT_CFG_CLEAR;

  always @* begin
    fail_cnt_nxt = fail_cnt_r;
    fail_outputs_nxt = fail_outputs;
    wd_reset_req_nxt = 1'b0;
    if (soft_reset) begin
      fail_cnt_nxt = 2'h0;
      fail_outputs_nxt = 1'b0;
    end else begin
      if (wd_trigger_fail) begin
        // Saturates so that a long run of failures cannot wrap to zero.
        if (fail_cnt_r != `FAIL_COUNT_MAX) begin
          fail_cnt_nxt = fail_cnt_r + 2'h1;
        end
        wd_reset_req_nxt = ~dev_mode_pin;
      end else if (wd_trigger_ok) begin
        fail_cnt_nxt = 2'h0;
      end
      if (fail_cnt_nxt >= fail_limit) begin
        fail_outputs_nxt = 1'b1;
      end
    end
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      fail_cnt_r <= 2'h0;
      fail_outputs <= 1'b0;
      wd_reset_req <= 1'b0;
    end else if (ce) begin
      fail_cnt_r <= fail_cnt_nxt;
      fail_outputs <= fail_outputs_nxt;
      wd_reset_req <= wd_reset_req_nxt;
    end
  end
endmodule // wake_and_supply_status_regs

// file: wake_supply_regs.vh
/*
 * Offsets, field positions, reset values and counts for the wake and supply
 * status register group. Definitions only; included by the design files.
 */
`ifndef WAKE_SUPPLY_REGS_VH
`define WAKE_SUPPLY_REGS_VH

// Register offsets on the 7-bit serial control port address.
`define ADDR_WAKE_A 7'h46
`define ADDR_WAKE_B 7'h47
`define ADDR_LEVEL 7'h48
`define ADDR_REGULATOR 7'h4C
`define ADDR_IDENT 7'h7E

// Wake source register A fields.
`define WKA_MODE_SWITCH 7
`define WKA_CAN 5
`define WKA_TIMER 4
`define WKA_PIN 0
`define WKA_RESERVED 6
`define WKA_RSVD_HI 3
`define WKA_RSVD_LO 1
`define WKA_RC_MASK 8'hB1

// Wake source register B: one flag per LIN bus in bits 3:0.
`define WKB_LIN1 0
`define WKB_LIN2 1
`define WKB_LIN3 2
`define WKB_LIN4 3
`define WKB_RSVD_HI 7
`define WKB_RSVD_LO 4
`define WKB_RC_MASK 4'hF

// Input level register fields.
`define LVL_DEV_PIN 7
`define LVL_FIXED_ONE 6
`define LVL_FAIL_CFG 5
`define LVL_WAKE_PIN 0
`define LVL_RSVD_HI 4
`define LVL_RSVD_LO 1

// Regulator fault register fields.
`define REG_BOOST_ACTIVE 7
`define REG_BOOST_SHORT 6
`define REG_BOOST_OPEN 5
`define REG_BOOST_GATE 4
`define REG_RESERVED 3
`define REG_BUCK_SHORT 2
`define REG_BUCK_OPEN 1
`define REG_OUT_RANGE 0
`define REG_RC_MASK 8'hF7
`define REG_UPPER_MASK 8'hF0

// Identification register fields.
`define ID_FAM_HI 7
`define ID_FAM_LO 4
`define ID_PRODUCT_VARIANT_CODE_HI 3
`define ID_PRODUCT_VARIANT_CODE_LO 0

// Reset values and watchdog failure thresholds.
`define RESET_ZERO 8'h00
`define FAIL_COUNT_CFG_SET 2'h1
`define FAIL_COUNT_CFG_CLEAR 2'h2
`define FAIL_COUNT_MAX 2'h3

`endif

// file: sticky_flags.v
/*
 * Bank of sticky status flags, one per bit, each set by a level or pulse and
 * cleared by a mask. Assumes one clock, synchronous active-low reset.
 */
`timescale 1ns/100ps
module sticky_flags #(
  parameter W = 8
) (
  // Clock, reset and enable.
  input wire clk_sys,
  input wire rstn,
  input wire ce,
  // Set and clear controls.
  input wire [W-1:0] set_in,
  input wire [W-1:0] clr_mask,
  input wire [W-1:0] init_mask,
  // Flag state.
  output wire [W-1:0] flags
);
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_flag
      reg flag_r;
      always @(posedge clk_sys) begin
        if (!rstn) begin
          flag_r <= 1'b0;
        end else if (ce) begin
          // A set in the same cycle as a clear wins.
          if (set_in[i]) begin
            flag_r <= 1'b1;
          end else if (clr_mask[i] || init_mask[i]) begin
            flag_r <= 1'b0;
          end
        end
      end
      assign flags[i] = flag_r;
    end
  endgenerate
endmodule // sticky_flags

// file: wake_supply_chk.sv
/* Assertion checker for the wake and supply status registers.
   Sees only the top module's ports and is bound in below. */
`timescale 1ns/100ps
module wake_supply_chk (
  // Clock and reset.
  input wire clk_sys,
  input wire rstn,
  // Inputs.
  input wire ce,
  input wire soft_reset,
  input wire [6:0] reg_addr,
  input wire reg_rd,
  input wire wake_input_pin,
  input wire dev_mode_pin,
  input wire fail_output_config_bit,
  input wire wd_trigger_fail,
  input wire wd_trigger_ok,
  // Outputs.
  input wire [7:0] reg_rdata,
  input wire reg_rvalid,
  input wire fail_outputs,
  input wire wd_reset_req
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  wire take = ce && reg_rd;
  chk_read_answer: assert property (take |=> reg_rvalid)
    else $error("no read answer");
  chk_answer_cause: assert property ($past(ce) && reg_rvalid |-> $past(reg_rd))
    else $error("answer without read");
  chk_reserved_wake: assert property (take && reg_addr == 7'h46 |=>
    (reg_rdata & 8'h4E) == 8'h00) else $error("wake reserved bits set");
  chk_reserved_lin: assert property (take && reg_addr == 7'h47 |=>
    reg_rdata[7:4] == 4'h0) else $error("lin reserved bits set");
  chk_level_map: assert property (take && reg_addr == 7'h48 |=>
    reg_rdata == {$past(dev_mode_pin), 1'b1, $past(fail_output_config_bit), 4'h0,
    $past(wake_input_pin)}) else $error("level register wrong");
  chk_wd_reset: assert property (ce && !soft_reset |=> wd_reset_req ==
    ($past(wd_trigger_fail) && !$past(dev_mode_pin))) else $error("reset request wrong");
  chk_fail_first: assert property (ce && wd_trigger_fail && fail_output_config_bit
    && !wd_trigger_ok && !soft_reset |=> fail_outputs) else $error("fail outputs late");
  chk_fail_cause: assert property ($rose(fail_outputs) |-> $past(wd_trigger_fail))
    else $error("fail outputs without failure");
  cover property (take && reg_addr == 7'h48);
  cover property ($rose(fail_outputs));
  cover property (wd_trigger_fail && dev_mode_pin);
endmodule // wake_supply_chk
bind wake_and_supply_status_regs wake_supply_chk u_chk (.*);

// file: tb_wake_and_supply_status_regs.sv
/* Bench for the wake and supply status registers.
   Drives every port itself; the checker is bound in. */
`timescale 1ns/100ps
module tb_wake_and_supply_status_regs;
  logic clk_sys, rstn, ce, soft_reset, reg_rd, reg_clr, reg_rvalid, wake_input_pin;
  logic dev_mode_pin, fail_output_config_bit, wd_trigger_fail, wd_trigger_ok;
  logic fail_outputs, wd_reset_req;
  logic [6:0] reg_addr;
  logic [7:0] reg_rdata;
  logic [3:0] lin_wake, w;
  logic [9:0] rg;
  integer fail_count = 0, compares = 0, i, n;
  logic [7:0] wx [0:3] = '{8'h01, 8'h10, 8'h20, 8'h80};
  logic [7:0] ex [0:9] = '{8'h01, 8'h02, 8'h04, 8'h10, 8'h20, 8'h20, 8'h20, 8'h40, 8'h40, 8'h80};
  wake_and_supply_status_regs DUT (.*, .regulator_mode_auto_switch(w[3]),
    .can_bus_wake(w[2]), .cyclic_timer_wake(w[1]), .wake_pin_wake(w[0]),
    .boost_running(rg[9]), .boost_diode_short(rg[8]), .positive_sense_short(rg[7]),
    .boost_diode_lost(rg[6]), .positive_sense_lost(rg[5]), .negative_sense_gnd_lost(rg[4]),
    .boost_gate_short(rg[3]), .buck_switch_short(rg[2]), .buck_switch_open(rg[1]),
    .main_output_out_of_band(rg[0]));
  task chk(input [7:0] s, input [7:0] e);
    compares++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task print_verdict;
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task rd(input [6:0] a, input [7:0] e);
    n = 0;
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    while (reg_rvalid !== 1'b1 && n < 8) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 8) begin
      fail_count++;
      print_verdict;
    end
    else chk(reg_rdata, e);
  endtask
  task clr(input [6:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_clr <= 1'b1;
    @(posedge clk_sys);
    reg_clr <= 1'b0;
  endtask
  task pu(input [3:0] a, input [9:0] b, input [3:0] l);
    @(posedge clk_sys);
    w <= a;
    rg <= b;
    lin_wake <= l;
    @(posedge clk_sys);
    w <= 4'h0;
    rg <= 10'h000;
    lin_wake <= 4'h0;
  endtask
  task wd(input f, input ok, input [7:0] e);
    @(posedge clk_sys);
    wd_trigger_fail <= f;
    wd_trigger_ok <= ok;
    @(posedge clk_sys);
    wd_trigger_fail <= 1'b0;
    wd_trigger_ok <= 1'b0;
    #1;
    chk({7'h00, wd_reset_req}, {7'h00, f & ~dev_mode_pin});
    @(posedge clk_sys);
    #1;
    chk({7'h00, fail_outputs}, e);
  endtask
  task sreset;
    @(posedge clk_sys);
    soft_reset <= 1'b1;
    @(posedge clk_sys);
    soft_reset <= 1'b0;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    {rstn, soft_reset, reg_rd, reg_clr, wd_trigger_fail, wd_trigger_ok} = 6'h00;
    {wake_input_pin, dev_mode_pin, fail_output_config_bit} = 3'h0;
    ce = 1'b1;
    reg_addr = 7'h00;
    w = 4'h0;
    rg = 10'h000;
    lin_wake = 4'h0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(7'h46, 8'h00);
    rd(7'h47, 8'h00);
    rd(7'h4C, 8'h00);
    rd(7'h7E, 8'hA3);
    rd(7'h50, 8'h00);
    for (i = 0; i < 4; i++) begin
      pu(4'h1 << i, 10'h000, 4'h0);
      rd(7'h46, wx[i]);
      clr(7'h46);
    end
    rd(7'h46, 8'h00);
    for (i = 0; i < 4; i++) begin
      pu(4'h0, 10'h000, 4'h1 << i);
      rd(7'h47, (8'h02 << i) - 8'h01);
    end
    clr(7'h47);
    rd(7'h47, 8'h00);
    for (i = 0; i < 10; i++) begin
      pu(4'h0, 10'h001 << i, 4'h0);
      rd(7'h4C, ex[i]);
      clr(7'h4C);
    end
    pu(4'hF, 10'h3FF, 4'hF);
    rd(7'h46, 8'hB1);
    rd(7'h4C, 8'hF7);
    sreset;
    rd(7'h46, 8'h00);
    rd(7'h47, 8'h00);
    rd(7'h4C, 8'h07);
    for (i = 0; i < 8; i++) begin
      @(posedge clk_sys);
      {dev_mode_pin, fail_output_config_bit, wake_input_pin} <= i[2:0];
      rd(7'h48, {i[2], 1'b1, i[1], 4'h0, i[0]});
    end
    wd(1'b1, 1'b0, 8'h01);
    @(posedge clk_sys);
    fail_output_config_bit <= 1'b0;
    dev_mode_pin <= 1'b0;
    sreset;
    wd(1'b1, 1'b0, 8'h00);
    wd(1'b0, 1'b1, 8'h00);
    wd(1'b1, 1'b0, 8'h00);
    wd(1'b1, 1'b0, 8'h01);
    @(posedge clk_sys);
    ce <= 1'b0;
    pu(4'h4, 10'h000, 4'h0);
    ce <= 1'b1;
    rd(7'h46, 8'h00);
    print_verdict;
  end
endmodule // tb_wake_and_supply_status_regs
